// ===== sim/dpbr_port_drv.sv
// partner model: user logic driving one port's clock and request
`timescale 1ns/1ps
`include "dpbr_defs.svh"

module dpbr_port_drv
  import dpbr_pkg::*;
(
  input  wire logic mclk,
  output logic      port_clock,
  output dpbr_req_t req
);
  // -------------------------------------------------------------
  // idle pins
  // -------------------------------------------------------------
  initial begin
    port_clock = 1'b0;
    req        = '0;
  end

  // -------------------------------------------------------------
  // one port access
  // -------------------------------------------------------------
  // setup sets how slow this partner runs, so two ports differ in period
  task automatic access(input logic [`DPBR_ADDR_W-1:0] addr,
                        input logic [`DPBR_DATA_W-1:0] data,
                        input logic en, input logic we, input logic rst,
                        input int setup);
    @(posedge mclk);
    req <= {addr, data, en, we, rst};
    repeat (setup) @(posedge mclk);             // held before the rise
    port_clock <= 1'b1;
    @(posedge mclk);
    req <= dpbr_req_t'(~req); // stale fields must not look valid after rise
    repeat (2) @(posedge mclk);
    port_clock <= 1'b0;
    repeat (4) @(posedge mclk); // clock stands low outside accesses
  endtask
endmodule

// ===== sim/dpbr_ram_checker.sv
// assertion checker for the dual-port block ram, bound to its top
`timescale 1ns/1ps
`include "dpbr_defs.svh"

module dpbr_ram_checker
  import dpbr_pkg::*;
(
  input wire logic                    mclk,
  input wire logic                    sys_rst,
  input wire logic                    port_a_clock,
  input wire dpbr_req_t               port_a_req,
  input wire logic                    port_b_clock,
  input wire dpbr_req_t               port_b_req,
  input wire logic [`DPBR_DATA_W-1:0] port_a_read_out,
  input wire logic [`DPBR_DATA_W-1:0] port_b_read_out,
  input wire logic                    clash_ww,
  input wire logic                    clash_a_bad,
  input wire logic                    clash_b_bad
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // -------------------------------------------------------------
  // request taken at each port rise, and cycles since it
  // -------------------------------------------------------------
  dpbr_req_t  seen_a_r;
  dpbr_req_t  seen_b_r;
  logic [3:0] age_a_r;
  logic [3:0] age_b_r;

  // port a capture; the age saturates so long gaps stay quiet
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      seen_a_r <= '0;
      age_a_r  <= 4'h0;
    end else if ($rose(port_a_clock)) begin
      seen_a_r <= port_a_req;
      age_a_r  <= 4'h0;
    end else if (age_a_r != 4'hF) begin
      age_a_r  <= age_a_r + 4'h1;
    end
  end

  // port b capture
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      seen_b_r <= '0;
      age_b_r  <= 4'h0;
    end else if ($rose(port_b_clock)) begin
      seen_b_r <= port_b_req;
      age_b_r  <= 4'h0;
    end else if (age_b_r != 4'hF) begin
      age_b_r  <= age_b_r + 4'h1;
    end
  end

  // -------------------------------------------------------------
  // access steps
  // -------------------------------------------------------------
  sequence a_wr_s;
    $rose(port_a_clock) && port_a_req.en && port_a_req.we && !port_a_req.rst;
  endsequence
  sequence b_wr_s;
    $rose(port_b_clock) && port_b_req.en && port_b_req.we && !port_b_req.rst;
  endsequence
  sequence a_clr_s;
    $rose(port_a_clock) && port_a_req.en && port_a_req.rst;
  endsequence

  reset_out_zero_a: assert property (disable iff (1'b0) sys_rst |=>
    port_a_read_out == 16'h0000 && port_b_read_out == 16'h0000)
    else $error("read outputs not cleared by reset");
  a_output_hold_a: assert property (age_a_r > 4'h6 |->
    $stable(port_a_read_out) || clash_a_bad)
    else $error("port a output moved without an access");
  b_output_hold_a: assert property (age_b_r > 4'h6 |->
    $stable(port_b_read_out) || clash_b_bad)
    else $error("port b output moved without an access");
  a_write_mirror_a: assert property (a_wr_s |-> ##[1:5]
    (port_a_read_out == seen_a_r.write_data_in || clash_ww))
    else $error("port a write data not mirrored");
  b_write_mirror_a: assert property (b_wr_s |-> ##[1:5]
    (port_b_read_out == seen_b_r.write_data_in || clash_ww))
    else $error("port b write data not mirrored");
  a_port_clear_a: assert property (a_clr_s |-> ##[1:5]
    port_a_read_out == `DPBR_OUT_RST)
    else $error("port a reset did not clear output");
  ww_same_cell_a: assert property (clash_ww |->
    seen_a_r.addr == seen_b_r.addr && seen_a_r.we && seen_b_r.we)
    else $error("write clash flagged without two writes to one cell");
  a_bad_cause_a: assert property (clash_a_bad |->
    port_a_read_out == `DPBR_INVALID_FILL &&
    seen_a_r.addr == seen_b_r.addr && seen_b_r.we)
    else $error("port a marked invalid without a clash");
  b_bad_cause_a: assert property (clash_b_bad |->
    port_b_read_out == `DPBR_INVALID_FILL &&
    seen_a_r.addr == seen_b_r.addr && seen_a_r.we)
    else $error("port b marked invalid without a clash");
endmodule

bind dpbr_ram dpbr_ram_checker i_chk (
  .mclk            (mclk),
  .sys_rst         (sys_rst),
  .port_a_clock    (port_a_clock),
  .port_a_req      (port_a_req),
  .port_b_clock    (port_b_clock),
  .port_b_req      (port_b_req),
  .port_a_read_out (port_a_read_out),
  .port_b_read_out (port_b_read_out),
  .clash_ww        (clash_ww),
  .clash_a_bad     (clash_a_bad),
  .clash_b_bad     (clash_b_bad)
);

// ===== sim/dpbr_ram_tb.sv
// self-checking bench for the dual-port block ram
`timescale 1ns/1ps
`include "dpbr_defs.svh"

module dpbr_ram_tb
  import dpbr_pkg::*;
;
  logic                    mclk;
  logic                    sys_rst;
  logic                    pa_clk;
  logic                    pb_clk;
  dpbr_req_t               pa_req;
  dpbr_req_t               pb_req;
  logic [`DPBR_DATA_W-1:0] a_out;
  logic [`DPBR_DATA_W-1:0] b_out;
  logic                    ww_f;
  logic                    a_bad_f;
  logic                    b_bad_f;
  int                      ww_n       = 0;
  int                      a_bad_n    = 0;
  int                      b_bad_n    = 0;
  int                      fail_count = 0;
  int                      compares   = 0;
  int                      cyc        = 0;

  dpbr_ram i_dut (
    .mclk(mclk), .sys_rst(sys_rst),
    .port_a_clock(pa_clk), .port_a_req(pa_req),
    .port_b_clock(pb_clk), .port_b_req(pb_req),
    .port_a_read_out(a_out), .port_b_read_out(b_out),
    .clash_ww(ww_f), .clash_a_bad(a_bad_f), .clash_b_bad(b_bad_f)
  );
  dpbr_port_drv i_pa (.mclk(mclk), .port_clock(pa_clk), .req(pa_req));
  dpbr_port_drv i_pb (.mclk(mclk), .port_clock(pb_clk), .req(pb_req));

  // -------------------------------------------------------------
  // clock, hang guard, shared tasks
  // -------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // ceiling well above the few hundred cycles the tests need
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      give_verdict();
    end
  end

  // count clash pulses; each flag stands for one mclk only
  always @(posedge mclk) begin
    if (ww_f === 1'b1) ww_n++;
    if (a_bad_f === 1'b1) a_bad_n++;
    if (b_bad_f === 1'b1) b_bad_n++;
  end

  task automatic check(input string name, input logic [15:0] exp,
                       input logic [15:0] seen);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task automatic t_idle();
    check("a_after_reset", 16'h0000, a_out);
    i_pa.access(8'h0F, 16'hFFFF, 1'b0, 1'b1, 1'b0, 4);
    check("a_no_access", 16'h0000, a_out);
    i_pa.access(8'h0F, 16'h1234, 1'b1, 1'b1, 1'b0, 4);
    check("a_write_mirror", 16'h1234, a_out);
    i_pa.access(8'h0F, 16'hFFFF, 1'b0, 1'b1, 1'b0, 4);
    check("a_disabled_hold", 16'h1234, a_out);
    i_pa.access(8'h0F, 16'h0000, 1'b1, 1'b0, 1'b0, 4);
    check("a_no_store_disabled", 16'h1234, a_out);
    $display("t_idle done");
  endtask

  task automatic t_single();
    i_pa.access(8'h7E, 16'h5678, 1'b1, 1'b1, 1'b0, 4);
    i_pa.access(8'h0F, 16'h0000, 1'b1, 1'b0, 1'b0, 4);
    check("a_read_0f", 16'h1234, a_out);
    i_pa.access(8'h7E, 16'h0000, 1'b0, 1'b0, 1'b1, 4);
    check("a_rst_disabled", 16'h1234, a_out);
    i_pa.access(8'h7E, 16'hBEEF, 1'b1, 1'b1, 1'b1, 4);
    check("a_rst_clear", 16'h0000, a_out);
    i_pa.access(8'h7E, 16'h0000, 1'b1, 1'b0, 1'b0, 4);
    check("a_mem_kept", 16'h5678, a_out);
    $display("t_single done");
  endtask

  task automatic t_cross();
    i_pb.access(8'h20, 16'h1111, 1'b1, 1'b1, 1'b0, 4);
    i_pa.access(8'h20, 16'hAAAA, 1'b1, 1'b1, 1'b0, 7);
    check("a_slow_write", 16'hAAAA, a_out);
    check("b_kept", 16'h1111, b_out);
    i_pb.access(8'h20, 16'h0000, 1'b1, 1'b0, 1'b0, 4); // window kept
    check("b_sees_a_write", 16'hAAAA, b_out);
    fork
      i_pa.access(8'h30, 16'h3333, 1'b1, 1'b1, 1'b0, 4);
      i_pb.access(8'h31, 16'h3131, 1'b1, 1'b1, 1'b0, 4);
    join
    check("a_same_time", 16'h3333, a_out);
    check("b_same_time", 16'h3131, b_out);
    fork
      i_pa.access(8'h31, 16'h0000, 1'b1, 1'b0, 1'b0, 4);
      i_pb.access(8'h30, 16'h0000, 1'b1, 1'b0, 1'b0, 4);
    join
    check("a_reads_b_cell", 16'h3131, a_out);
    check("b_reads_a_cell", 16'h3333, b_out);
    check("no_ww_flag", 16'h0000, 16'(ww_n));
    check("no_a_bad_flag", 16'h0000, 16'(a_bad_n));
    check("no_b_bad_flag", 16'h0000, 16'(b_bad_n));
    $display("t_cross done");
  endtask

  task automatic t_clash();
    int w0;
    int a0;
    int b0;
    w0 = ww_n;
    a0 = a_bad_n;
    b0 = b_bad_n;
    fork
      i_pa.access(8'h40, 16'h9999, 1'b1, 1'b1, 1'b0, 4);
      i_pb.access(8'h40, 16'h7777, 1'b1, 1'b1, 1'b0, 4);
    join
    i_pa.access(8'h40, 16'h0000, 1'b1, 1'b0, 1'b0, 4);
    check("ww_cell_invalid", `DPBR_INVALID_FILL, a_out);
    fork
      i_pa.access(8'h41, 16'h4444, 1'b1, 1'b1, 1'b0, 4);
      i_pb.access(8'h41, 16'h0000, 1'b1, 1'b0, 1'b0, 4);
    join
    check("wr_writer_out", 16'h4444, a_out);
    check("wr_reader_out", `DPBR_INVALID_FILL, b_out);
    i_pb.access(8'h41, 16'h0000, 1'b1, 1'b0, 1'b0, 4);
    check("wr_write_kept", 16'h4444, b_out);
    // read first, write one mclk later: the reader is spoiled afterwards
    fork
      i_pa.access(8'h42, 16'h0000, 1'b1, 1'b0, 1'b0, 4);
      i_pb.access(8'h42, 16'hB0B0, 1'b1, 1'b1, 1'b0, 5);
    join
    check("late_reader_out", `DPBR_INVALID_FILL, a_out);
    check("late_writer_out", 16'hB0B0, b_out);
    i_pa.access(8'h42, 16'h0000, 1'b1, 1'b0, 1'b0, 4);
    check("late_write_kept", 16'hB0B0, a_out);
    // two writes one mclk apart still fall inside the window
    fork
      i_pa.access(8'h43, 16'h5555, 1'b1, 1'b1, 1'b0, 4);
      i_pb.access(8'h43, 16'h6666, 1'b1, 1'b1, 1'b0, 5);
    join
    check("ww_late_a_mirror", 16'h5555, a_out);
    check("ww_late_b_mirror", 16'h6666, b_out);
    i_pb.access(8'h43, 16'h0000, 1'b1, 1'b0, 1'b0, 4);
    check("ww_late_invalid", `DPBR_INVALID_FILL, b_out);
    check("ww_flag_count", 16'h0002, 16'(ww_n - w0));
    check("a_bad_count", 16'h0001, 16'(a_bad_n - a0));
    check("b_bad_count", 16'h0001, 16'(b_bad_n - b0));
    $display("t_clash done");
  endtask

  task automatic t_rerst();
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge mclk);
    check("a_mid_reset", 16'h0000, a_out);
    check("b_mid_reset", 16'h0000, b_out);
    $display("t_rerst done");
  endtask

  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge mclk);
    t_idle();
    t_single();
    t_cross();
    t_clash();
    t_rerst();
    give_verdict();
  end
endmodule

// ===== src/dpbr_defs.svh
// constants of the dual-port block ram: widths, fill value, timing figures
// Contract
// - each port clock rise samples address, write data, enable, strobe, reset
// - enabled with strobe low reads the addressed word onto that port output
// - enabled with strobe high stores write data and mirrors it on output
// - disabled port does nothing and its output holds its last value
// - after reset memory starts disabled, no access until enable sampled
// - two independent ports, each may reach any location, even the same
// - each port runs from its own clock, unrelated in period and phase
// - window matters only for equal addresses with at least one write
// - write-write clash inside window leaves that location invalid
// - write-read clash: write good, writer mirrors, reader output invalid
// - a write never alters the other port output outside a clash
// - read after other port write, window met, returns the new value
`ifndef DPBR_DEFS_SVH
`define DPBR_DEFS_SVH

// geometry
`define DPBR_ADDR_W         8
`define DPBR_DATA_W         16
`define DPBR_DEPTH          256

// value that stands for invalid data after a clash
`define DPBR_INVALID_FILL   16'hDEAD

// cross-port setup window, in ns, and the system clock rate
`define DPBR_SETUP_WIN_NS   10
`define DPBR_MCLK_MHZ       200

// value a port output takes on system or port reset
`define DPBR_OUT_RST        16'h0000

`endif

// ===== src/dpbr_pkg.sv
// types shared by the dual-port block ram modules
`include "dpbr_defs.svh"

package dpbr_pkg;

  // ---------------------------------------------------------------
  // one port's request as seen on its pins
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [`DPBR_ADDR_W-1:0] addr;
    logic [`DPBR_DATA_W-1:0] write_data_in;
    logic                    en;
    logic                    we;
    logic                    rst;
  } dpbr_req_t;

  // ---------------------------------------------------------------
  // clash verdicts for one port edge
  // ---------------------------------------------------------------
  typedef struct packed {
    logic ww;         // location written twice inside the window
    logic a_rd_bad;   // port a read now hits a b write
    logic a_late_bad; // b write lands on port a's recent read
    logic b_rd_bad;   // port b read now hits an a write
    logic b_late_bad; // a write lands on port b's recent read
  } dpbr_clash_t;

endpackage

// ===== src/dpbr_port_in.sv
// pin front end of one port: synchronises clock and request, finds the edge
`timescale 1ns/1ps
`include "dpbr_defs.svh"

module dpbr_port_in
  import dpbr_pkg::*;
(
  input  wire logic      mclk,
  input  wire logic      sys_rst,
  input  wire logic      port_clock,
  input  wire dpbr_req_t pin_req,
  output dpbr_req_t      req,
  output logic           strobe
);

  logic      clk_s1_r;
  logic      clk_s2_r;
  logic      clk_s3_r;
  dpbr_req_t req_s1_r;
  dpbr_req_t req_s2_r;
  dpbr_req_t req_s3_r;

  // ---------------------------------------------------------------
  // synchronisers
  // ---------------------------------------------------------------
  // clock pin through two flops, a third for edge detection
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      clk_s1_r <= 1'b0;
      clk_s2_r <= 1'b0;
      clk_s3_r <= 1'b0;
    end else begin
      clk_s1_r <= port_clock;
      clk_s2_r <= clk_s1_r;
      clk_s3_r <= clk_s2_r;
    end
  end

  // request one stage deeper than the clock: the partner changes its pins
  // right after its own edge, so we keep the value from before that edge
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      req_s1_r <= '0;
      req_s2_r <= '0;
      req_s3_r <= '0;
    end else begin
      req_s1_r <= pin_req;
      req_s2_r <= req_s1_r;
      req_s3_r <= req_s2_r;
    end
  end

  // one mclk pulse per port clock rise, request held alongside
  assign strobe = clk_s2_r & ~clk_s3_r;
  assign req    = req_s3_r;

endmodule

// ===== src/dpbr_ram.sv
// dual-port block ram top: memory array, two ports, clash handling
`timescale 1ns/1ps
`include "dpbr_defs.svh"

module dpbr_ram
  import dpbr_pkg::*;
#(
  parameter int WIN_NS   = `DPBR_SETUP_WIN_NS,
  parameter int MCLK_MHZ = `DPBR_MCLK_MHZ
)
(
  input  wire logic                    mclk,
  input  wire logic                    sys_rst,
  input  wire logic                    port_a_clock,
  input  wire dpbr_req_t               port_a_req,
  input  wire logic                    port_b_clock,
  input  wire dpbr_req_t               port_b_req,
  output logic [`DPBR_DATA_W-1:0]      port_a_read_out,
  output logic [`DPBR_DATA_W-1:0]      port_b_read_out,
  output logic                         clash_ww,
  output logic                         clash_a_bad,
  output logic                         clash_b_bad
);

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  // setup window in mclk cycles, rounded up, never below one
  localparam int WIN_RAW = (WIN_NS * MCLK_MHZ + 999) / 1000;
  localparam int WIN_CYC = (WIN_RAW < 1) ? 1 : WIN_RAW;

  localparam logic [`DPBR_DATA_W-1:0] FILL    = `DPBR_INVALID_FILL;
  localparam logic [`DPBR_DATA_W-1:0] OUT_RST = `DPBR_OUT_RST;

  // ---------------------------------------------------------------
  // storage and state
  // ---------------------------------------------------------------
  // no reset on the array: contents are undefined until written
  logic [`DPBR_DATA_W-1:0] mem [`DPBR_DEPTH];

  logic [`DPBR_DATA_W-1:0] port_a_read_out_r;
  logic [`DPBR_DATA_W-1:0] port_b_read_out_r;
  logic                    clash_ww_r;
  logic                    clash_a_bad_r;
  logic                    clash_b_bad_r;

  dpbr_req_t               req_a;
  dpbr_req_t               req_b;
  logic                    strobe_a;
  logic                    strobe_b;
  dpbr_clash_t             clash;
  logic                    en_a;
  logic                    en_b;
  logic                    wr_a;
  logic                    wr_b;

  // ---------------------------------------------------------------
  // pin front ends, one per port
  // ---------------------------------------------------------------
  // each port keeps its own clock; both are sampled on mclk, so each
  // port clock must be well below mclk for its edges to be seen
  dpbr_port_in u_port_a (
    .mclk       (mclk),
    .sys_rst    (sys_rst),
    .port_clock (port_a_clock),
    .pin_req    (port_a_req),
    .req        (req_a),
    .strobe     (strobe_a)
  );

  dpbr_port_in u_port_b (
    .mclk       (mclk),
    .sys_rst    (sys_rst),
    .port_clock (port_b_clock),
    .pin_req    (port_b_req),
    .req        (req_b),
    .strobe     (strobe_b)
  );

  // ---------------------------------------------------------------
  // clash tracker
  // ---------------------------------------------------------------
  // the user is meant to keep out of the window; this only defines
  // what happens when that promise is broken
  dpbr_window #(
    .WIN_CYC (WIN_CYC)
  ) u_window (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .strobe_a (strobe_a),
    .req_a    (req_a),
    .strobe_b (strobe_b),
    .req_b    (req_b),
    .clash    (clash)
  );

  // ---------------------------------------------------------------
  // access decode
  // ---------------------------------------------------------------
  // enabled edge per port; port reset blocks the memory access
  assign en_a = strobe_a & req_a.en;
  assign en_b = strobe_b & req_b.en;
  assign wr_a = en_a & req_a.we & ~req_a.rst;
  assign wr_b = en_b & req_b.we & ~req_b.rst;

  // ---------------------------------------------------------------
  // memory writes
  // ---------------------------------------------------------------
  // both ports may write in the same cycle, to any address; a double
  // write inside the window leaves the fill pattern in the cell
  always_ff @(posedge mclk) begin
    if (wr_a) begin
      mem[req_a.addr] <= clash.ww ? FILL : req_a.write_data_in;
    end
    if (wr_b) begin
      mem[req_b.addr] <= clash.ww ? FILL : req_b.write_data_in;
    end
  end

  // ---------------------------------------------------------------
  // port a output
  // ---------------------------------------------------------------
  // writer always mirrors its own data, even inside a clash
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      port_a_read_out_r <= OUT_RST;
    end else if (en_a) begin
      if (req_a.rst) begin
        port_a_read_out_r <= OUT_RST;
      end else if (req_a.we) begin
        port_a_read_out_r <= req_a.write_data_in;
      end else if (clash.a_rd_bad) begin
        port_a_read_out_r <= FILL;
      end else begin
        port_a_read_out_r <= mem[req_a.addr];
      end
    end else if (clash.a_late_bad) begin
      port_a_read_out_r <= FILL;
    end
    // otherwise hold: disabled edges and other-port writes leave it
  end

  // ---------------------------------------------------------------
  // port b output
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      port_b_read_out_r <= OUT_RST;
    end else if (en_b) begin
      if (req_b.rst) begin
        port_b_read_out_r <= OUT_RST;
      end else if (req_b.we) begin
        port_b_read_out_r <= req_b.write_data_in;
      end else if (clash.b_rd_bad) begin
        port_b_read_out_r <= FILL;
      end else begin
        port_b_read_out_r <= mem[req_b.addr];
      end
    end else if (clash.b_late_bad) begin
      port_b_read_out_r <= FILL;
    end
  end

  // ---------------------------------------------------------------
  // clash flags
  // ---------------------------------------------------------------
  // one-cycle pulses so user logic can log broken window promises
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      clash_ww_r    <= 1'b0;
      clash_a_bad_r <= 1'b0;
      clash_b_bad_r <= 1'b0;
    end else begin
      clash_ww_r    <= clash.ww;
      clash_a_bad_r <= clash.a_rd_bad | clash.a_late_bad;
      clash_b_bad_r <= clash.b_rd_bad | clash.b_late_bad;
    end
  end

  // all outputs straight from flops
  assign port_a_read_out = port_a_read_out_r;
  assign port_b_read_out = port_b_read_out_r;
  assign clash_ww        = clash_ww_r;
  assign clash_a_bad     = clash_a_bad_r;
  assign clash_b_bad     = clash_b_bad_r;

endmodule

// ===== src/dpbr_window.sv
// cross-port setup window tracker: spots same-address clashes
`timescale 1ns/1ps
`include "dpbr_defs.svh"

module dpbr_window
  import dpbr_pkg::*;
#(
  parameter int WIN_CYC = 2
)
(
  input  wire logic      mclk,
  input  wire logic      sys_rst,
  input  wire logic      strobe_a,
  input  wire dpbr_req_t req_a,
  input  wire logic      strobe_b,
  input  wire dpbr_req_t req_b,
  output dpbr_clash_t    clash
);

  localparam int CW = $clog2(WIN_CYC + 1);
  localparam logic [CW-1:0] WIN_LOAD = CW'(WIN_CYC);

  logic [CW-1:0]           cnt_a_r;
  logic [CW-1:0]           cnt_b_r;
  logic [`DPBR_ADDR_W-1:0] addr_a_r;
  logic [`DPBR_ADDR_W-1:0] addr_b_r;
  logic                    we_a_r;
  logic                    we_b_r;
  logic                    act_a;
  logic                    act_b;
  logic                    same_now;
  logic                    a_vs_hb;
  logic                    b_vs_ha;

  // a reset edge is no access, so it opens no window
  assign act_a = strobe_a & req_a.en & ~req_a.rst;
  assign act_b = strobe_b & req_b.en & ~req_b.rst;

  // ---------------------------------------------------------------
  // window history per port
  // ---------------------------------------------------------------
  // last access of each port stays live for WIN_CYC cycles
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cnt_a_r  <= '0;
      addr_a_r <= '0;
      we_a_r   <= 1'b0;
    end else if (act_a) begin
      cnt_a_r  <= WIN_LOAD;
      addr_a_r <= req_a.addr;
      we_a_r   <= req_a.we;
    end else if (cnt_a_r != '0) begin
      cnt_a_r <= cnt_a_r - CW'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cnt_b_r  <= '0;
      addr_b_r <= '0;
      we_b_r   <= 1'b0;
    end else if (act_b) begin
      cnt_b_r  <= WIN_LOAD;
      addr_b_r <= req_b.addr;
      we_b_r   <= req_b.we;
    end else if (cnt_b_r != '0) begin
      cnt_b_r <= cnt_b_r - CW'(1);
    end
  end

  // ---------------------------------------------------------------
  // clash verdicts
  // ---------------------------------------------------------------
  // only equal addresses count; read-read never clashes
  assign same_now = act_a & act_b & (req_a.addr == req_b.addr);
  assign a_vs_hb  = act_a & (cnt_b_r != '0) & (req_a.addr == addr_b_r);
  assign b_vs_ha  = act_b & (cnt_a_r != '0) & (req_b.addr == addr_a_r);

  // two writes inside the window
  assign clash.ww = (same_now & req_a.we & req_b.we)
                  | (a_vs_hb & req_a.we & we_b_r)
                  | (b_vs_ha & req_b.we & we_a_r);

  // a read that meets a write, now or one still in the window
  assign clash.a_rd_bad = (same_now & ~req_a.we & req_b.we)
                        | (a_vs_hb & ~req_a.we & we_b_r);
  assign clash.b_rd_bad = (same_now & ~req_b.we & req_a.we)
                        | (b_vs_ha & ~req_b.we & we_a_r);

  // a write that arrives just after the other port's read
  assign clash.a_late_bad = b_vs_ha & req_b.we & ~we_a_r;
  assign clash.b_late_bad = a_vs_hb & req_a.we & ~we_b_r;

endmodule
